// ===== logic/aer_avalon_slave.sv
`timescale 1ns/1ps

module aer_avalon_slave #(
  parameter int ADDR_W = 12
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  aer_bus_if.slave bus
);
  aer_pkg::slave_state_t q;
  aer_pkg::slave_state_t d;

  // one wait cycle; read data captured while waitrequest is high
  always_comb
  begin
    d = q;
    unique case (q.st)
      aer_pkg::BUS_IDLE:
      begin
        if (read || write)
        begin
          d.st = aer_pkg::BUS_DONE;
        end
        if (read)
        begin
          d.rdata = bus.rdata;
        end
      end
      aer_pkg::BUS_DONE:
      begin
        d.st = aer_pkg::BUS_IDLE;
      end
      default:
      begin
        d.st = aer_pkg::BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '{st: aer_pkg::BUS_IDLE, rdata: 32'h0000_0000};
    end
    else
    begin
      q <= d;
    end
  end

  assign waitrequest = (read || write) && (q.st != aer_pkg::BUS_DONE);
  assign readdata = q.rdata;
  assign bus.addr = address;
  assign bus.wdata = writedata;
  assign bus.be = byteenable;
  assign bus.wr = write && (q.st == aer_pkg::BUS_DONE);

endmodule // aer_avalon_slave

// ===== logic/aer_bus_if.sv
`timescale 1ns/1ps

interface aer_bus_if #(
  parameter int ADDR_W = 12
);
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic wr;
  logic [31:0] rdata;

  modport slave (output addr, output wdata, output be, output wr, input rdata);
  modport regs (input addr, input wdata, input be, input wr, output rdata);
endinterface

// ===== logic/aer_err_report.sv
`timescale 1ns/1ps
`include "aer_map.svh"

module aer_err_report (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] events,
  input wire logic [31:0] mask,
  input wire logic downstream,
  output logic hdr_log_req,
  output logic err_msg_req,
  output logic [31:0] err_msg_bits
);
  aer_pkg::report_state_t q;
  aer_pkg::report_state_t d;
  logic [31:0] allow;

  // masked errors never reach the header log or the message path
  always_comb
  begin
    d = q;
    allow = downstream ? `AER_IMPL : (`AER_IMPL & ~`AER_SDOWN_MASK);
    d.bits = events & allow & ~mask;
    d.hdr_log = |d.bits;
    d.err_msg = |d.bits;
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '{hdr_log: 1'b0, err_msg: 1'b0, bits: 32'h0000_0000};
    end
    else
    begin
      q <= d;
    end
  end

  assign hdr_log_req = q.hdr_log;
  assign err_msg_req = q.err_msg;
  assign err_msg_bits = q.bits;

endmodule // aer_err_report

// ===== logic/aer_map.svh
`ifndef AER_MAP_SVH
`define AER_MAP_SVH

`define AER_OFS_HEADER 12'h100
`define AER_OFS_STATUS 12'h104
`define AER_OFS_MASK 12'h108

`define AER_CAP_ID 16'h0001
`define AER_CAP_VER 4'h1
`define AER_CAP_NEXT 12'h140

`define AER_IMPL 32'h003F_F031
`define AER_SDOWN_MASK 32'h0000_0020
`define AER_STATUS_RESET 32'h0000_0000
`define AER_MASK_RESET 32'h0000_0000

`define AER_B_TRAIN 0
`define AER_B_DLP 4
`define AER_B_SDOWN 5
`define AER_B_POISON 12
`define AER_B_FCP 13
`define AER_B_CTO 14
`define AER_B_CA 15
`define AER_B_UC 16
`define AER_B_RXOVF 17
`define AER_B_MALF 18
`define AER_B_ECRC 19
`define AER_B_UR 20
`define AER_B_ACS 21

`endif

// ===== logic/aer_pkg.sv
package aer_pkg;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_DONE = 2'b10
  } bus_state_t;

  typedef struct packed {
    bus_state_t st;
    logic [31:0] rdata;
  } slave_state_t;

  typedef struct packed {
    logic [31:0] status;
    logic [31:0] mask;
    logic ds_meta;
    logic ds_q;
  } sticky_state_t;

  typedef struct packed {
    logic hdr_log;
    logic err_msg;
    logic [31:0] bits;
  } report_state_t;

endpackage

// ===== logic/aer_regs.sv
// Operation
// - capability header bits 15:0 read 0001h, writes ignored
// - capability version bits 19:16 read-only value 1h
// - next capability pointer bits 31:20 read-only 140h
// - status bit 0 sets on training error, sticky, write-one-clear
// - status bit 4 sets on data link protocol error, sticky, W1C
// - status bit 5 surprise down, downstream ports only, sticky, W1C
// - status bit 12 sets on poisoned packet received or generated
// - status bit 13 sets on flow control protocol error
// - status bit 14 sets on completion timeout
// - status bit 15 sets on completer abort
// - status bit 16 sets on unexpected completion
// - status bit 17 sets on receiver overflow
// - status bit 18 sets on malformed packet
// - status bit 19 sets on end-to-end CRC error
// - status bit 20 sets on unsupported request
// - status bit 21 sets on access control violation
// - mask bits sticky RW; set mask blocks header log and message
// - surprise down mask applies only on downstream ports
`timescale 1ns/1ps
`include "aer_map.svh"

module aer_regs #(
  parameter int ADDR_W = 12
) (
  input wire logic CLK_SYS,
  input wire logic RST,
  input wire logic PWR_ON_RST,
  input wire logic DOWNSTREAM_PORT,
  input wire logic [21:0] UNCORR_ERR_EVENT,
  input wire logic [ADDR_W-1:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic HDR_LOG_REQ,
  output logic ERR_MSG_REQ,
  output logic [31:0] ERR_MSG_BITS
);

  generate
    if (ADDR_W < 12)
    begin : g_addr_check
      $error("ADDR_W must cover the 4 KB configuration space");
    end
  endgenerate

  aer_bus_if #(.ADDR_W(ADDR_W)) bus ();

  aer_pkg::sticky_state_t q;
  aer_pkg::sticky_state_t d;
  logic [31:0] ev;
  logic [31:0] ds_allow;
  logic [31:0] bmask;
  logic [31:0] clr_vec;
  logic wr_status;
  logic wr_mask;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    logic [31:0] m;
    m = 32'h0000_0000;
    for (int i = 0; i < 4; i++)
    begin
      m[i*8 +: 8] = {8{be[i]}};
    end
    return m;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [11:0] ofs);
    return a == ADDR_W'(ofs);
  endfunction

  aer_avalon_slave #(.ADDR_W(ADDR_W)) u_slave (
    .clk(CLK_SYS),
    .rst(RST),
    .address(AVS_ADDRESS),
    .read(AVS_READ),
    .write(AVS_WRITE),
    .writedata(AVS_WRITEDATA),
    .byteenable(AVS_BYTEENABLE),
    .readdata(AVS_READDATA),
    .waitrequest(AVS_WAITREQUEST),
    .bus(bus.slave)
  );

  aer_err_report u_report (
    .clk(CLK_SYS),
    .rst(RST),
    .events(ev),
    .mask(q.mask),
    .downstream(q.ds_q),
    .hdr_log_req(HDR_LOG_REQ),
    .err_msg_req(ERR_MSG_REQ),
    .err_msg_bits(ERR_MSG_BITS)
  );

  // surprise down exists only on a downstream port
  assign ds_allow = q.ds_q ? 32'hFFFF_FFFF : ~`AER_SDOWN_MASK;
  assign ev = {10'h000, UNCORR_ERR_EVENT} & `AER_IMPL & ds_allow;
  assign bmask = lane_mask(bus.be);
  assign wr_status = bus.wr && hit(bus.addr, `AER_OFS_STATUS);
  assign wr_mask = bus.wr && hit(bus.addr, `AER_OFS_MASK);
  assign clr_vec = wr_status ? (bus.wdata & bmask) : 32'h0000_0000;

  always_comb
  begin
    d = q;
    d.ds_meta = DOWNSTREAM_PORT;
    d.ds_q = q.ds_meta;
    // a new event wins over a clear in the same cycle; mask not consulted
    d.status = (q.status & ~clr_vec) | ev;
    d.status = d.status & `AER_IMPL;
    if (wr_mask)
    begin
      d.mask = (q.mask & ~bmask) | (bus.wdata & bmask);
    end
    d.mask = d.mask & `AER_IMPL & ds_allow;
    d.status = d.status & ds_allow;
  end

  // sticky state answers only to power-on reset
  always_ff @(posedge CLK_SYS or posedge PWR_ON_RST)
  begin
    if (PWR_ON_RST)
    begin
      q <= '{status: `AER_STATUS_RESET, mask: `AER_MASK_RESET,
             ds_meta: 1'b0, ds_q: 1'b0};
    end
    else
    begin
      q <= d;
    end
  end

  always_comb
  begin
    bus.rdata = 32'h0000_0000;
    if (hit(bus.addr, `AER_OFS_HEADER))
    begin
      bus.rdata = {`AER_CAP_NEXT, `AER_CAP_VER, `AER_CAP_ID};
    end
    else if (hit(bus.addr, `AER_OFS_STATUS))
    begin
      bus.rdata = q.status;
    end
    else if (hit(bus.addr, `AER_OFS_MASK))
    begin
      bus.rdata = q.mask;
    end
  end

  a_hdr_id_read: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST || RST)
    AVS_READ && !AVS_WAITREQUEST && hit(AVS_ADDRESS, `AER_OFS_HEADER)
    |-> AVS_READDATA[15:0] == `AER_CAP_ID)
    else $error("capability id wrong");

  a_hdr_ver_read: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST || RST)
    AVS_READ && !AVS_WAITREQUEST && hit(AVS_ADDRESS, `AER_OFS_HEADER)
    |-> AVS_READDATA[19:16] == `AER_CAP_VER)
    else $error("capability version wrong");

  a_hdr_next_read: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST || RST)
    AVS_READ && !AVS_WAITREQUEST && hit(AVS_ADDRESS, `AER_OFS_HEADER)
    |-> AVS_READDATA[31:20] == `AER_CAP_NEXT)
    else $error("next capability pointer wrong");

  a_train_set: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    ev[`AER_B_TRAIN] |=> q.status[`AER_B_TRAIN])
    else $error("training error not recorded");

  a_dlp_set: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    ev[`AER_B_DLP] |=> q.status[`AER_B_DLP])
    else $error("data link protocol error not recorded");

  a_sdown_set: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    UNCORR_ERR_EVENT[`AER_B_SDOWN] && q.ds_q && $past(q.ds_q)
    |=> q.status[`AER_B_SDOWN])
    else $error("surprise down not recorded");

  a_sdown_upstream: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    !q.ds_q |-> !q.status[`AER_B_SDOWN] || $past(q.ds_q))
    else $error("surprise down set on upstream port");

  a_poison_set: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    ev[`AER_B_POISON] |=> q.status[`AER_B_POISON])
    else $error("poisoned packet not recorded");

  a_fcp_set: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    ev[`AER_B_FCP] |=> q.status[`AER_B_FCP])
    else $error("flow control error not recorded");

  a_cto_set: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    ev[`AER_B_CTO] |=> q.status[`AER_B_CTO])
    else $error("completion timeout not recorded");

  a_ca_set: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    ev[`AER_B_CA] |=> q.status[`AER_B_CA])
    else $error("completer abort not recorded");

  a_uc_set: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    ev[`AER_B_UC] |=> q.status[`AER_B_UC])
    else $error("unexpected completion not recorded");

  a_rxovf_set: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    ev[`AER_B_RXOVF] |=> q.status[`AER_B_RXOVF])
    else $error("receiver overflow not recorded");

  a_malf_set: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    ev[`AER_B_MALF] |=> q.status[`AER_B_MALF])
    else $error("malformed packet not recorded");

  a_ecrc_set: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    ev[`AER_B_ECRC] |=> q.status[`AER_B_ECRC])
    else $error("crc error not recorded");

  a_ur_set: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    ev[`AER_B_UR] |=> q.status[`AER_B_UR])
    else $error("unsupported request not recorded");

  a_acs_set: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    ev[`AER_B_ACS] |=> q.status[`AER_B_ACS])
    else $error("access violation not recorded");

  a_status_w1c: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    wr_status && ev == 32'h0000_0000
    |=> (q.status & $past(clr_vec)) == 32'h0000_0000)
    else $error("write-one did not clear status");

  a_status_hold: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    !wr_status && ev == 32'h0000_0000 && $stable(q.ds_q) |=> $stable(q.status))
    else $error("status bit changed without cause");

  a_mask_write: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    wr_mask && bus.be == 4'hF && q.ds_q && $past(q.ds_q)
    |=> q.mask == ($past(bus.wdata) & `AER_IMPL))
    else $error("mask write not stored");

  a_mask_blocks: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST || RST)
    ev != 32'h0000_0000 && (ev & ~q.mask) == 32'h0000_0000
    |=> !HDR_LOG_REQ && !ERR_MSG_REQ)
    else $error("masked error was reported");

  a_unmasked_reports: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST || RST)
    (ev & ~q.mask) != 32'h0000_0000 |=> HDR_LOG_REQ && ERR_MSG_REQ)
    else $error("unmasked error not reported");

  a_sdown_mask: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST || RST)
    ev == `AER_SDOWN_MASK && q.mask[`AER_B_SDOWN] |=> !ERR_MSG_REQ)
    else $error("masked surprise down reported");

  a_rsvd_zero: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST || RST)
    AVS_READ && !AVS_WAITREQUEST && !hit(AVS_ADDRESS, `AER_OFS_HEADER)
    |-> (AVS_READDATA & ~`AER_IMPL) == 32'h0000_0000)
    else $error("reserved bits read non-zero");

  a_sticky_reset: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    RST && ev == 32'h0000_0000 && $stable(q.ds_q) |=> $stable(q.status) && $stable(q.mask))
    else $error("sticky bits lost on port reset");

  a_masked_sets: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    (ev & q.mask) != 32'h0000_0000 |=> (q.status & $past(ev)) == $past(ev))
    else $error("masked error did not set status");

  a_read_status: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST || RST)
    AVS_READ && !AVS_WAITREQUEST && hit(AVS_ADDRESS, `AER_OFS_STATUS)
    |-> AVS_READDATA == $past(q.status))
    else $error("status read data wrong");

  a_read_mask: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST || RST)
    AVS_READ && !AVS_WAITREQUEST && hit(AVS_ADDRESS, `AER_OFS_MASK)
    |-> AVS_READDATA == $past(q.mask))
    else $error("mask read data wrong");

  a_wait_first: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (AVS_READ || AVS_WRITE) && !$past(AVS_READ || AVS_WRITE) |-> AVS_WAITREQUEST)
    else $error("new request not held off");

  a_wait_done: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("request not answered after one wait cycle");

  a_bits_idle: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    !ERR_MSG_REQ |-> ERR_MSG_BITS == 32'h0000_0000)
    else $error("message bits without message");

  a_log_msg_pair: assert property (
    @(posedge CLK_SYS) disable iff (RST)
    HDR_LOG_REQ == ERR_MSG_REQ)
    else $error("header log and message disagree");

  a_w1c_keeps: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    wr_status && $stable(q.ds_q)
    |=> ($past(q.status) & ~$past(clr_vec) & ~q.status) == 32'h0000_0000)
    else $error("status bit cleared without a one written");

  a_sdown_no_bits: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST || RST)
    !q.ds_q |=> !ERR_MSG_BITS[`AER_B_SDOWN])
    else $error("surprise down reported on upstream port");

  a_mask_rsvd: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    (q.mask & ~`AER_IMPL) == 32'h0000_0000)
    else $error("reserved mask bit set");

  a_status_rsvd: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    (q.status & ~`AER_IMPL) == 32'h0000_0000)
    else $error("reserved status bit set");

  a_ds_sync: assert property (
    @(posedge CLK_SYS) disable iff (PWR_ON_RST)
    q.ds_q == $past(q.ds_meta))
    else $error("port strap not passed through two stages");

endmodule // aer_regs

// ===== test/advanced_error_reporting_regs_tb.sv
`timescale 1ns/1ps

module advanced_error_reporting_regs_tb;
  logic CLK_SYS = 1'b0;
  logic RST = 1'b1;
  logic PWR_ON_RST = 1'b1;
  logic DOWNSTREAM_PORT = 1'b1;
  logic [21:0] UNCORR_ERR_EVENT;
  logic [11:0] AVS_ADDRESS = 12'h000;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [31:0] AVS_WRITEDATA = 32'h0000_0000;
  logic [3:0] AVS_BYTEENABLE = 4'hF;
  logic [31:0] AVS_READDATA;
  logic AVS_WAITREQUEST;
  logic HDR_LOG_REQ;
  logic ERR_MSG_REQ;
  logic [31:0] ERR_MSG_BITS;
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int bl[13] = '{0, 4, 5, 12, 13, 14, 15, 16, 17, 18, 19, 20, 21};

  always #5 CLK_SYS = ~CLK_SYS;

  aer_regs #(.ADDR_W(12)) DUT (
    .CLK_SYS(CLK_SYS),
    .RST(RST),
    .PWR_ON_RST(PWR_ON_RST),
    .DOWNSTREAM_PORT(DOWNSTREAM_PORT),
    .UNCORR_ERR_EVENT(UNCORR_ERR_EVENT),
    .AVS_ADDRESS(AVS_ADDRESS),
    .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE),
    .AVS_WRITEDATA(AVS_WRITEDATA),
    .AVS_BYTEENABLE(AVS_BYTEENABLE),
    .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST),
    .HDR_LOG_REQ(HDR_LOG_REQ),
    .ERR_MSG_REQ(ERR_MSG_REQ),
    .ERR_MSG_BITS(ERR_MSG_BITS)
  );

  err_partner partner (
    .clk(CLK_SYS),
    .ev(UNCORR_ERR_EVENT),
    .hdr_log(HDR_LOG_REQ),
    .err_msg(ERR_MSG_REQ),
    .bits(ERR_MSG_BITS)
  );

  task automatic end_of_test();
    $display("failures=%0d n_tests=%0d", failures, n_tests);
    if (failures == 0 && n_tests > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // one Avalon transfer, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    @(posedge CLK_SYS);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_BYTEENABLE <= be;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    @(posedge CLK_SYS);
    while (AVS_WAITREQUEST !== 1'b0)
      @(posedge CLK_SYS);
    q = AVS_READDATA;
    AVS_READ <= 1'b0;
    AVS_WRITE <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h0000_0000, 4'hF, q);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b1, a, d, be, q);
  endtask

  // event pulse, then the report outputs in the cycle after
  task automatic fire(input logic [21:0] v, input logic [33:0] exp);
    partner.pulse(v);
    #1;
    check({30'h0000_0000, HDR_LOG_REQ, ERR_MSG_REQ}, {30'h0000_0000, exp[33:32]});
    check(ERR_MSG_BITS, exp[31:0]);
  endtask

  always @(posedge CLK_SYS)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      end_of_test();
    end
  end

  initial
  begin
    logic [31:0] q;
    logic [31:0] b;
    repeat (5) @(posedge CLK_SYS);
    RST <= 1'b0;
    PWR_ON_RST <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    rd(12'h100, q);
    check(q, 32'h1401_0001);
    wr(12'h100, 32'h0000_0000, 4'hF);
    rd(12'h100, q);
    check(q, 32'h1401_0001);
    rd(12'h104, q);
    check(q, 32'h0000_0000);
    rd(12'h108, q);
    check(q, 32'h0000_0000);
    rd(12'h10C, q);
    check(q, 32'h0000_0000);
    foreach (bl[i])
    begin
      b = 32'h0000_0001 << bl[i];
      fire(b[21:0], {2'b11, b});
      rd(12'h104, q);
      check(q, b);
      wr(12'h104, b, 4'hF);
      rd(12'h104, q);
      check(q, 32'h0000_0000);
    end
    wr(12'h108, 32'hFFFF_FFFF, 4'h1);
    rd(12'h108, q);
    check(q, 32'h0000_0031);
    wr(12'h108, 32'hFFFF_FFFF, 4'hF);
    rd(12'h108, q);
    check(q, 32'h003F_F031);
    fire(22'h00_0020, 34'h0_0000_0000);
    fire(22'h3F_FFFF, 34'h0_0000_0000);
    rd(12'h104, q);
    check(q, 32'h003F_F031);
    @(posedge CLK_SYS);
    RST <= 1'b1;
    repeat (2) @(posedge CLK_SYS);
    RST <= 1'b0;
    rd(12'h104, q);
    check(q, 32'h003F_F031);
    rd(12'h108, q);
    check(q, 32'h003F_F031);
    wr(12'h104, 32'h0000_4000, 4'hF);
    rd(12'h104, q);
    check(q, 32'h003F_B031);
    @(posedge CLK_SYS);
    PWR_ON_RST <= 1'b1;
    DOWNSTREAM_PORT <= 1'b0;
    repeat (2) @(posedge CLK_SYS);
    PWR_ON_RST <= 1'b0;
    repeat (3) @(posedge CLK_SYS);
    rd(12'h104, q);
    check(q, 32'h0000_0000);
    wr(12'h108, 32'hFFFF_FFFF, 4'hF);
    rd(12'h108, q);
    check(q, 32'h003F_F011);
    wr(12'h108, 32'h0000_0000, 4'hF);
    fire(22'h00_0020, 34'h0_0000_0000);
    rd(12'h104, q);
    check(q, 32'h0000_0000);
    check(partner.msgs, 13);
    check(partner.logs, 13);
    check(partner.last_bits, 32'h0020_0000);
    end_of_test();
  end
endmodule // advanced_error_reporting_regs_tb

// ===== test/err_partner.sv
`timescale 1ns/1ps

module err_partner (
  input wire logic clk,
  output logic [21:0] ev,
  input wire logic hdr_log,
  input wire logic err_msg,
  input wire logic [31:0] bits
);
  int msgs = 0;
  int logs = 0;
  logic [31:0] last_bits = 32'h0000_0000;

  initial ev = 22'h00_0000;

  // one-cycle event pulse, launched just after an edge
  task automatic pulse(input logic [21:0] v);
    @(posedge clk);
    ev <= v;
    @(posedge clk);
    ev <= 22'h00_0000;
  endtask

  // receiver side: count every report pulse
  always @(posedge clk)
  begin
    if (err_msg === 1'b1)
    begin
      msgs++;
      last_bits <= bits;
    end
    if (hdr_log === 1'b1)
      logs++;
  end
endmodule // err_partner
